// ===== rtl/cad_pkg.sv
// Constants shared by the processor-side decode block and its bus master
// Overview of operation
// RULE1: Master divides crystal by four, paces bus
// RULE2: Read-not-write high reads, low writes
// RULE3: Hold system reset low 690 ms
// RULE4: Divide bus clock by 2048 for tick
// RULE5: Bus adapter interrupt drives fast interrupt
// RULE6: I/O adapter interrupt drives non-maskable interrupt
// RULE7: Fast interrupt stacks only flags, counter
// RULE8: Non-maskable interrupt can never be masked
// RULE9: Sixteen-bit address, eight-bit data bus
// RULE10: Decode ROM, two RAMs, non-volatile RAM
// RULE11: Decode bus adapter and I/O adapter
// RULE12: Strobes for segment latches and multiplier
// RULE13: Write 0000 multiplicand, read product high
// RULE14: Write 0002 multiplier, read product low
// RULE15: Sixteen by sixteen multiply, 75 ns
// RULE16: High byte staged, low write loads word
// RULE17: Latch holds low byte of product word
// RULE18: Write 1081 clears tick divider, request
// RULE19: Unmapped address selects nothing, no effect
package cad_pkg;
	// Clocking
	localparam longint CLK_HZ        = 50_000_000;
	localparam longint XTAL_HZ       = 8_000_000;
	localparam int     XTAL_DIV      = 4;
	localparam int     BUS_CYC       = int'(CLK_HZ * XTAL_DIV / XTAL_HZ);  // 25 clocks
	localparam int     Q_PHASE       = BUS_CYC / 4;                        // Q leads E
	localparam int     TICK_DIV      = 2048;
	localparam longint RST_HOLD_MS   = 690;
	localparam longint RST_HOLD_CYC  = RST_HOLD_MS * CLK_HZ / 1000;
	localparam longint MULT_NS       = 75;
	localparam int     MULT_CYC      = int'((MULT_NS * CLK_HZ + 999_999_999) / 1_000_000_000);
	// Memory map
	localparam logic [15:0] A_MCAND    = 16'h0000;
	localparam logic [15:0] A_MPLIER   = 16'h0002;
	localparam logic [15:0] A_SEG_A    = 16'h1000;
	localparam logic [15:0] A_SEG_B    = 16'h1040;
	localparam logic [15:0] A_AUX      = 16'h1080;
	localparam logic [15:0] A_TICK_CLR = 16'h1081;
	localparam logic [15:0] A_BIA_LO   = 16'h1100;
	localparam logic [15:0] A_BIA_HI   = 16'h1107;
	localparam logic [15:0] A_VIO_LO   = 16'h1200;
	localparam logic [15:0] A_VIO_HI   = 16'h120F;
	localparam logic [15:0] A_NVR_LO   = 16'h1400;
	localparam logic [15:0] A_NVR_HI   = 16'h17FF;
	localparam logic [15:0] A_RAM1_LO  = 16'h2000;
	localparam logic [15:0] A_RAM1_HI  = 16'h3FFF;
	localparam logic [15:0] A_RAM2_LO  = 16'h4000;
	localparam logic [15:0] A_RAM2_HI  = 16'h5FFF;
	localparam logic [15:0] A_ROM_LO   = 16'h6000;
	localparam logic [7:0]  UNMAPPED_RD = 8'hFF;
	// Master APB register offsets
	localparam logic [11:0] R_ADDR    = 12'h000;
	localparam logic [11:0] R_WDATA   = 12'h004;
	localparam logic [11:0] R_CTRL    = 12'h008;
	localparam logic [11:0] R_STATUS  = 12'h00C;
	localparam logic [11:0] R_INT_ST  = 12'h010;
	localparam logic [11:0] R_INT_MSK = 12'h014;
	// Control and status bits
	localparam int CTRL_GO  = 0;
	localparam int CTRL_RNW = 1;
	localparam int ST_BUSY  = 8;
	localparam int ST_RST   = 9;
	localparam int ST_IRQ   = 10;
	localparam int ST_FAST_INTERRUPT_REQUEST  = 11;
	localparam int ST_NMI   = 12;
	// Interrupt status bits
	localparam int EV_DONE = 0;
	localparam int EV_IRQ  = 1;
	localparam int EV_FAST_INTERRUPT_REQUEST = 2;
	localparam int EV_NMI  = 3;
	localparam int EV_W    = 4;
	// Chip select bit positions
	localparam int CS_ROM = 0;
	localparam int CS_RAM1 = 1;
	localparam int CS_RAM2 = 2;
	localparam int CS_NVR = 3;
	localparam int CS_BIA = 4;
	localparam int CS_VIO = 5;
	localparam int CS_W   = 6;
endpackage

// ===== rtl/cad_bus_if.sv
// Processor memory bus between the bus master and the decode block
`timescale 1ns/100ps
`default_nettype none
interface cad_bus_if;
	logic [15:0] addr;                       // Address bus
	logic [7:0]  wdata;                      // Write data
	logic [7:0]  rdata;                      // Read data
	logic        rnw;                        // High read, low write
	logic        vld;                        // Valid memory address
	logic        e_stb;                      // Main bus clock, one pulse per period
	logic        q_stb;                      // Quadrature bus clock pulse
	logic        sys_rst_n;                  // System reset
	logic        irq_n;                      // Tick interrupt request
	logic        fast_interrupt_request_n;   // Bus adapter interrupt
	logic        nmi_n;                      // I/O adapter interrupt
	modport dev (
		input  addr, wdata, rnw, vld, e_stb, q_stb,
		output rdata, sys_rst_n, irq_n, fast_interrupt_request_n, nmi_n
	);
	modport host (
		output addr, wdata, rnw, vld, e_stb, q_stb,
		input  rdata, sys_rst_n, irq_n, fast_interrupt_request_n, nmi_n
	);
endinterface
`default_nettype wire

// ===== rtl/cad_dev.sv
// Address decode, reset generator, tick divider and multiplier ports
//
// Design decision made in the bus master, not here: the APB register port.
`timescale 1ns/100ps
`default_nettype none
module cad_dev #(
	parameter longint RST_HOLD = cad_pkg::RST_HOLD_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	cad_bus_if.dev           bus,
	input  wire logic [7:0]  ext_rdata,
	input  wire logic        bia_irq_n,
	input  wire logic        vio_irq_n,
	output logic [cad_pkg::CS_W-1:0] cs_q,
	output logic             wr_en_q,
	output logic [15:0]      seg_a_q,
	output logic [15:0]      seg_b_q
);
	// Inclusive range check
	function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo,
			input logic [15:0] hi);
		in_rng = (a >= lo) && (a <= hi);
	endfunction

	logic [31:0] rst_cnt_q;
	logic        rst_n_q;
	logic [10:0] tick_cnt_q;
	logic        irq_n_q;
	logic        fast_interrupt_request_n_q;
	logic        nmi_n_q;
	logic [15:0] mcand_q;
	logic [15:0] mplier_q;
	logic [7:0]  stage_q;
	logic [7:0]  lo_latch_q;
	logic [31:0] prod_q;
	logic [7:0]  rdata_q;
	logic        armed_q;

	// Address decode
	wire [15:0] a       = bus.addr;
	wire        hit_rom  = a >= cad_pkg::A_ROM_LO;                               // see RULE10
	wire        hit_ram1 = in_rng(a, cad_pkg::A_RAM1_LO, cad_pkg::A_RAM1_HI);     // see RULE10
	wire        hit_ram2 = in_rng(a, cad_pkg::A_RAM2_LO, cad_pkg::A_RAM2_HI);     // see RULE10
	wire        hit_nvr  = in_rng(a, cad_pkg::A_NVR_LO, cad_pkg::A_NVR_HI);       // see RULE10
	wire        hit_bia  = in_rng(a, cad_pkg::A_BIA_LO, cad_pkg::A_BIA_HI);       // see RULE11
	wire        hit_vio  = in_rng(a, cad_pkg::A_VIO_LO, cad_pkg::A_VIO_HI);       // see RULE11
	wire        hit_mca  = a == cad_pkg::A_MCAND;                                // see RULE12
	wire        hit_mpl  = a == cad_pkg::A_MPLIER;                               // see RULE12
	wire        hit_sega = in_rng(a, cad_pkg::A_SEG_A, cad_pkg::A_SEG_A + 16'h0001); // see RULE12
	wire        hit_segb = in_rng(a, cad_pkg::A_SEG_B, cad_pkg::A_SEG_B + 16'h0001); // see RULE12
	wire        hit_aux  = a == cad_pkg::A_AUX;
	wire        hit_tclr = a == cad_pkg::A_TICK_CLR;
	wire        ext_hit  = hit_rom | hit_ram1 | hit_ram2 | hit_nvr | hit_bia | hit_vio;

	// Bus transfer strobes, direction from read-not-write
	wire        xfer   = bus.vld & bus.e_stb & armed_q & rst_n_q;              // see RULE1
	wire        wr_stb = xfer & ~bus.rnw;                                       // see RULE2
	wire        rd_stb = xfer & bus.rnw;                                        // see RULE2
	wire [15:0] mult_load = {stage_q, bus.wdata};                               // see RULE16
	wire        tick_wrap = bus.e_stb && tick_cnt_q == 11'(cad_pkg::TICK_DIV - 1);
	wire        tick_clr  = wr_stb & hit_tclr;                                  // see RULE18

	// Arm on Q of a valid cycle; a stray E before it takes nothing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			armed_q <= 1'b0;
		else if (!bus.vld || bus.e_stb)
			armed_q <= 1'b0;
		else if (bus.q_stb)
			armed_q <= 1'b1;                                                    // see RULE1
	end

	// Read data selection; unmapped reads give a fixed value, no side effect
	wire [7:0] rd_mux = hit_mca  ? prod_q[31:24] :                             // see RULE13
	                    hit_mpl  ? prod_q[15:8]  :                             // see RULE14
	                    hit_aux  ? lo_latch_q    :                             // see RULE17
	                    ext_hit  ? ext_rdata     :
	                    cad_pkg::UNMAPPED_RD;                                   // see RULE19

	// Chip selects and direction, registered; none for unmapped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cs_q    <= '0;
			wr_en_q <= 1'b0;
		end else begin
			cs_q    <= bus.vld ? {hit_vio, hit_bia, hit_nvr, hit_ram2, hit_ram1, hit_rom}
			                   : '0;                                            // see RULE19
			wr_en_q <= bus.vld & ~bus.rnw;                                      // see RULE2
		end
	end

	// Power-up reset hold
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_cnt_q <= '0;
			rst_n_q   <= 1'b0;
		end else if (!rst_n_q) begin
			rst_cnt_q <= rst_cnt_q + 32'd1;
			rst_n_q   <= (rst_cnt_q == 32'(RST_HOLD - 1));                      // see RULE3
		end
	end

	// Periodic tick from main bus clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_q <= '0;
			irq_n_q    <= 1'b1;
		end else if (!rst_n_q || tick_clr) begin
			tick_cnt_q <= '0;                                                   // see RULE18
			irq_n_q    <= 1'b1;
		end else begin
			if (bus.e_stb)
				tick_cnt_q <= tick_cnt_q + 11'd1;                               // see RULE4
			if (tick_wrap)
				irq_n_q <= 1'b0;                                                // see RULE4
		end
	end

	// Adapter interrupts routed onto the processor inputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fast_interrupt_request_n_q <= 1'b1;
			nmi_n_q  <= 1'b1;
		end else begin
			fast_interrupt_request_n_q <= bia_irq_n;                                              // see RULE5
			nmi_n_q  <= vio_irq_n;                                              // see RULE6
		end
	end

	// Multiplier operands and staging latch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mcand_q  <= '0;
			mplier_q <= '0;
			stage_q  <= '0;
		end else if (wr_stb) begin
			if (hit_aux)
				stage_q <= bus.wdata;                                           // see RULE16
			else if (hit_mca)
				mcand_q <= mult_load;                                           // see RULE13
			else if (hit_mpl)
				mplier_q <= mult_load;                                          // see RULE14
		end
	end

	// Product register, ready one clock after an operand load
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prod_q <= '0;
		else
			prod_q <= mcand_q * mplier_q;                                       // see RULE15
	end

	// Low byte of a product word caught on its high-byte read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			lo_latch_q <= '0;
		else if (rd_stb && hit_mca)
			lo_latch_q <= prod_q[23:16];                                        // see RULE17
		else if (rd_stb && hit_mpl)
			lo_latch_q <= prod_q[7:0];                                          // see RULE17
	end

	// Segment latches
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seg_a_q <= '0;
			seg_b_q <= '0;
		end else if (wr_stb) begin
			if (hit_sega && a[0])
				seg_a_q[15:8] <= bus.wdata;
			else if (hit_sega)
				seg_a_q[7:0] <= bus.wdata;
			else if (hit_segb && a[0])
				seg_b_q[15:8] <= bus.wdata;
			else if (hit_segb)
				seg_b_q[7:0] <= bus.wdata;
		end
	end

	// Read data register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rdata_q <= '0;
		else
			rdata_q <= rd_mux;                                                  // see RULE9
	end

	assign bus.rdata                    = rdata_q;
	assign bus.sys_rst_n                = rst_n_q;
	assign bus.irq_n                    = irq_n_q;
	assign bus.fast_interrupt_request_n = fast_interrupt_request_n_q;
	assign bus.nmi_n                    = nmi_n_q;
endmodule // cad_dev
`default_nettype wire

// ===== rtl/cad_host.sv
// Bus master that runs processor bus cycles on orders given over APB
`timescale 1ns/100ps
`default_nettype none
module cad_host (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq,
	cad_bus_if.host          bus
);
	typedef enum logic [1:0] {IDLE, WAIT_Q, WAIT_E} cad_st_e;

	cad_st_e           st_q;
	logic [4:0]        div_q;
	logic              e_q;
	logic              qs_q;
	logic [15:0]       addr_q;
	logic [7:0]        wdata_q;
	logic              rnw_q;
	logic              vld_q;
	logic [7:0]        rdata_q;
	logic [cad_pkg::EV_W-1:0] ist_q;
	logic [cad_pkg::EV_W-1:0] imsk_q;
	logic [2:0]        lines_q;

	// APB decode
	wire apb_wr  = psel & penable & pwrite;
	wire apb_rd  = psel & ~penable & ~pwrite;
	wire wr_addr = apb_wr && paddr == cad_pkg::R_ADDR;
	wire wr_wdat = apb_wr && paddr == cad_pkg::R_WDATA;
	wire wr_ctrl = apb_wr && paddr == cad_pkg::R_CTRL;
	wire wr_ist  = apb_wr && paddr == cad_pkg::R_INT_ST;
	wire wr_imsk = apb_wr && paddr == cad_pkg::R_INT_MSK;
	wire go      = wr_ctrl && pwdata[cad_pkg::CTRL_GO] && st_q == IDLE && bus.sys_rst_n;
	wire done    = st_q == WAIT_E && e_q;
	wire [2:0] lines_now = {~bus.nmi_n, ~bus.fast_interrupt_request_n, ~bus.irq_n};
	wire [2:0] rise      = lines_now & ~lines_q;
	wire [cad_pkg::EV_W-1:0] ev = {rise, done};
	wire [31:0] st_word = {19'd0, lines_now, bus.sys_rst_n, st_q != IDLE, rdata_q};
	wire [31:0] rd_mux =
		(paddr == cad_pkg::R_ADDR)    ? {16'd0, addr_q} :
		(paddr == cad_pkg::R_WDATA)   ? {24'd0, wdata_q} :
		(paddr == cad_pkg::R_CTRL)    ? {30'd0, rnw_q, 1'b0} :
		(paddr == cad_pkg::R_STATUS)  ? st_word :
		(paddr == cad_pkg::R_INT_ST)  ? {28'd0, ist_q} :
		(paddr == cad_pkg::R_INT_MSK) ? {28'd0, imsk_q} : 32'd0;

	// Bus clock divider: E and quadrature Q at crystal rate over four
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= '0;
			e_q   <= 1'b0;
			qs_q  <= 1'b0;
		end else begin
			div_q <= (div_q == 5'(cad_pkg::BUS_CYC - 1)) ? 5'd0 : div_q + 5'd1; // see RULE1
			e_q   <= div_q == 5'(cad_pkg::BUS_CYC - 1);                       // see RULE1
			qs_q  <= div_q == 5'(cad_pkg::BUS_CYC - 1 - cad_pkg::Q_PHASE);     // see RULE1
		end
	end

	// Transfer sequencing: Q then E completes the cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q    <= IDLE;
			vld_q   <= 1'b0;
			rnw_q   <= 1'b1;
			rdata_q <= '0;
		end else begin
			case (st_q)
				IDLE: begin
					if (go) begin
						st_q  <= WAIT_Q;
						vld_q <= 1'b1;
						rnw_q <= pwdata[cad_pkg::CTRL_RNW];                     // see RULE2
					end
				end
				WAIT_Q: begin
					if (qs_q)
						st_q <= WAIT_E;
				end
				default: begin
					if (e_q) begin
						st_q    <= IDLE;
						vld_q   <= 1'b0;
						rnw_q   <= 1'b1;
						rdata_q <= rnw_q ? bus.rdata : rdata_q;                 // see RULE9
					end
				end
			endcase
		end
	end

	// Order registers, held while a cycle runs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_q  <= '0;
			wdata_q <= '0;
		end else if (st_q == IDLE) begin
			if (wr_addr)
				addr_q <= pwdata[15:0];                                         // see RULE9
			if (wr_wdat)
				wdata_q <= pwdata[7:0];                                         // see RULE9
		end
	end

	// Interrupt status, set wins over write-one clear; NMI cannot be masked
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lines_q <= '0;
			ist_q   <= '0;
			imsk_q  <= '0;
			irq     <= 1'b0;
		end else begin
			lines_q <= lines_now;
			ist_q   <= (ist_q & ~(wr_ist ? pwdata[cad_pkg::EV_W-1:0] : '0)) | ev;
			if (wr_imsk)
				imsk_q <= pwdata[cad_pkg::EV_W-1:0];
			irq <= |(ist_q & (imsk_q | (cad_pkg::EV_W'(1) << cad_pkg::EV_NMI))); // see RULE8
		end
	end

	// APB answer: zero wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= '0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= 1'b0;
			if (apb_rd)
				prdata <= rd_mux;
		end
	end

	assign bus.addr  = addr_q;
	assign bus.wdata = wdata_q;
	assign bus.rnw   = rnw_q;
	assign bus.vld   = vld_q;
	assign bus.e_stb = e_q;
	assign bus.q_stb = qs_q;
endmodule // cad_host
`default_nettype wire

// ===== tb/cad_assertions.sv
// Concurrent checks on the processor bus between master and decoder
`timescale 1ns/100ps
`default_nettype none
module cad_assertions #(
	parameter longint RST_HOLD = 20
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic [15:0] addr,
	input wire logic [7:0]  wdata,
	input wire logic [7:0]  rdata,
	input wire logic        rnw,
	input wire logic        vld,
	input wire logic        e_stb,
	input wire logic        q_stb,
	input wire logic        sys_rst_n,
	input wire logic        irq_n
);
	logic [31:0] rst_cnt_q;
	logic [11:0] tick_cnt_q;
	logic [4:0]  gap_q;
	logic        seen_q;
	logic        arm_q;
	// Decoded places and bus events; a transfer needs Q before its E
	wire take  = vld & e_stb & arm_q & sys_rst_n;
	wire clr   = take & ~rnw & (addr == 16'h1081);
	wire mapd  = (addr == 16'h0000) | (addr == 16'h0002) | (addr[15:1] == 15'h0800)
		| (addr[15:1] == 15'h0820) | (addr[15:1] == 15'h0840) | (addr[15:3] == 13'h0220)
		| (addr[15:4] == 12'h120) | (addr[15:10] == 6'h05) | (addr >= 16'h2000);
	// Cycles since reset, bus clocks since tick clear, gap between bus clocks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_cnt_q  <= 32'h0000_0000;
			tick_cnt_q <= 12'h000;
			gap_q      <= 5'h00;
			seen_q     <= 1'b0;
			arm_q      <= 1'b0;
		end else begin
			arm_q      <= vld & ~e_stb & (arm_q | q_stb);
			rst_cnt_q  <= (&rst_cnt_q) ? rst_cnt_q : rst_cnt_q + 32'h0000_0001;
			tick_cnt_q <= clr ? 12'h000 : (e_stb & sys_rst_n & ~&tick_cnt_q) ? tick_cnt_q + 12'h001
				: tick_cnt_q;
			gap_q      <= e_stb ? 5'h00 : gap_q + 5'h01;
			seen_q     <= seen_q | e_stb;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_rst_low; rst_cnt_q < RST_HOLD |-> !sys_rst_n; endproperty
	a_rst_low: assert property (p_rst_low) else $error("system reset released early");
	property p_rst_rel; rst_cnt_q > RST_HOLD |-> sys_rst_n; endproperty
	a_rst_rel: assert property (p_rst_rel) else $error("system reset held too long");
	property p_q_lead; q_stb |-> ##6 e_stb; endproperty
	a_q_lead: assert property (p_q_lead) else $error("quadrature clock out of phase");
	property p_e_period; e_stb && seen_q |-> gap_q == 5'd24; endproperty
	a_e_period: assert property (p_e_period) else $error("bus clock period wrong");
	property p_idle_rnw; !vld |-> rnw; endproperty
	a_idle_rnw: assert property (p_idle_rnw) else $error("direction not read when idle");
	property p_hold; vld && !e_stb |=> $stable({addr, rnw, wdata}); endproperty
	a_hold: assert property (p_hold) else $error("request changed mid transfer");
	property p_unmap; take && rnw && !mapd |-> rdata == 8'hFF; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read value wrong");
	property p_tick_early; tick_cnt_q < 12'h800 |-> irq_n; endproperty
	a_tick_early: assert property (p_tick_early) else $error("tick request early");
	property p_tick_fire; tick_cnt_q == 12'h800 |-> !irq_n; endproperty
	a_tick_fire: assert property (p_tick_fire) else $error("tick request missing");
	property p_tick_keep; !irq_n && !clr |=> !irq_n; endproperty
	a_tick_keep: assert property (p_tick_keep) else $error("tick request dropped");
	property p_tick_clr; clr |-> ##[1:2] irq_n; endproperty
	a_tick_clr: assert property (p_tick_clr) else $error("tick request not withdrawn");
endmodule // cad_assertions
`default_nettype wire

// ===== tb/cad_tb_top.sv
// Self-checking bench: APB-driven bus master facing the decode block
`timescale 1ns/100ps
`default_nettype none
module cad_tb_top;
	localparam int          RST_HOLD = 20;
	localparam int          TMO      = 90000;
	localparam logic [31:0] PROD     = 32'h0000_1234 * 32'h0000_ABCD;
	typedef struct packed {
		logic [15:0] a;
		logic        r;
		logic [7:0]  d;
		logic [5:0]  cs;
		logic [7:0]  rd;
	} cad_row_s;
	logic                     pclk      = 1'b0;
	logic                     presetn   = 1'b0;
	logic                     psel      = 1'b0;
	logic                     penable   = 1'b0;
	logic                     pwrite    = 1'b0;
	logic [11:0]              paddr     = 12'h000;
	logic [31:0]              pwdata    = 32'h0000_0000;
	logic [7:0]               ext_rdata = 8'h00;
	logic                     bia_irq_n = 1'b1;
	logic                     vio_irq_n = 1'b1;
	logic [31:0]              prdata;
	logic                     pready;
	logic                     pslverr;
	logic                     irq;
	logic [cad_pkg::CS_W-1:0] cs_q;
	logic [cad_pkg::CS_W-1:0] cs_seen;
	logic                     wr_en_q;
	logic                     we_seen;
	logic [15:0]              seg_a_q;
	logic [15:0]              seg_b_q;
	int                       err_count = 0;
	int                       compares  = 0;
	int                       cyc       = 0;
	cad_row_s                 rows [30];
	cad_bus_if bus ();
	// Both ends and the bus checker
	cad_host u_cad_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .bus(bus.host));
	cad_dev #(.RST_HOLD(RST_HOLD)) u_cad_dev (.pclk(pclk), .presetn(presetn), .bus(bus.dev),
		.ext_rdata(ext_rdata), .bia_irq_n(bia_irq_n), .vio_irq_n(vio_irq_n), .cs_q(cs_q),
		.wr_en_q(wr_en_q), .seg_a_q(seg_a_q), .seg_b_q(seg_b_q));
	cad_assertions #(.RST_HOLD(RST_HOLD)) u_cad_assertions (.pclk(pclk), .presetn(presetn),
		.addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata), .rnw(bus.rnw), .vld(bus.vld),
		.e_stb(bus.e_stb), .q_stb(bus.q_stb), .sys_rst_n(bus.sys_rst_n), .irq_n(bus.irq_n));
	// Clock
	always #10 pclk = ~pclk;
	// Hang guard
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == TMO) begin
			err_count++;
			end_of_test();
		end
	end
	// Select and direction seen at the taking edge
	always @(posedge pclk) begin
		if (bus.vld && bus.e_stb) begin
			cs_seen <= cs_q;
			we_seen <= wr_en_q;
		end
	end
	task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic end_of_test();
		$display("Compares %0d, errors %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		check("slave error", 32'h0000_0000, {31'h0000_0000, pslverr});
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] q);
		apb(1'b0, a, 32'h0000_0000, q);
	endtask
	// One processor bus cycle, waiting out the busy flag
	task automatic xfer(input logic [15:0] a, input logic r, input logic [7:0] d,
		output logic [7:0] q);
		logic [31:0] s;
		wr(cad_pkg::R_ADDR, {16'h0000, a});
		wr(cad_pkg::R_WDATA, {24'h00_0000, d});
		wr(cad_pkg::R_CTRL, {30'h0000_0000, r, 1'b1});
		do rd(cad_pkg::R_STATUS, s); while (s[cad_pkg::ST_BUSY] !== 1'b0);
		q = s[7:0];
	endtask
	// Main sequence
	initial begin
		logic [7:0]  q;
		logic [31:0] s;
		int          n;
		rows = '{'{16'h6000, 1'b1, 8'h00, 6'h01, 8'h00}, '{16'hFFFF, 1'b1, 8'h00, 6'h01, 8'h00},
			'{16'h2000, 1'b0, 8'h11, 6'h02, 8'h00}, '{16'h3FFF, 1'b1, 8'h00, 6'h02, 8'h00},
			'{16'h4000, 1'b1, 8'h00, 6'h04, 8'h00}, '{16'h5FFF, 1'b0, 8'h22, 6'h04, 8'h00},
			'{16'h1400, 1'b1, 8'h00, 6'h08, 8'h00}, '{16'h17FF, 1'b0, 8'h33, 6'h08, 8'h00},
			'{16'h1100, 1'b1, 8'h00, 6'h10, 8'h00}, '{16'h1107, 1'b0, 8'h44, 6'h10, 8'h00},
			'{16'h1200, 1'b1, 8'h00, 6'h20, 8'h00}, '{16'h120F, 1'b0, 8'h55, 6'h20, 8'h00},
			'{16'h0001, 1'b1, 8'h00, 6'h00, 8'hFF}, '{16'h1108, 1'b1, 8'h00, 6'h00, 8'hFF},
			'{16'h1210, 1'b1, 8'h00, 6'h00, 8'hFF}, '{16'h13FF, 1'b1, 8'h00, 6'h00, 8'hFF},
			'{16'h1800, 1'b1, 8'h00, 6'h00, 8'hFF}, '{16'h1FFF, 1'b1, 8'h00, 6'h00, 8'hFF},
			'{16'h1000, 1'b0, 8'h11, 6'h00, 8'h00}, '{16'h1001, 1'b0, 8'h22, 6'h00, 8'h00},
			'{16'h1040, 1'b0, 8'h33, 6'h00, 8'h00}, '{16'h1041, 1'b0, 8'h44, 6'h00, 8'h00},
			'{16'h1080, 1'b0, 8'h12, 6'h00, 8'h00}, '{16'h0000, 1'b0, 8'h34, 6'h00, 8'h00},
			'{16'h1080, 1'b0, 8'hAB, 6'h00, 8'h00}, '{16'h0002, 1'b0, 8'hCD, 6'h00, 8'h00},
			'{16'h0000, 1'b1, 8'h00, 6'h00, PROD[31:24]}, '{16'h1080, 1'b1, 8'h00, 6'h00, PROD[23:16]},
			'{16'h0002, 1'b1, 8'h00, 6'h00, PROD[15:8]}, '{16'h1080, 1'b1, 8'h00, 6'h00, PROD[7:0]}};
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(cad_pkg::R_STATUS, s);
		check("reset held", 1'b0, s[cad_pkg::ST_RST]);
		while (bus.sys_rst_n !== 1'b1) @(posedge pclk);
		foreach (rows[i]) begin
			ext_rdata <= rows[i].a[7:0] ^ 8'h5A;
			xfer(rows[i].a, rows[i].r, rows[i].d, q);
			check("chip select", 32'(rows[i].cs), 32'(cs_seen));
			if (rows[i].cs != 6'h00)
				check("write strobe", !rows[i].r, we_seen);
			if (rows[i].r)
				check("read data", (rows[i].cs != 6'h00) ? rows[i].a[7:0] ^ 8'h5A : rows[i].rd,
					q);
		end
		check("segment pair a", 16'h2211, seg_a_q);
		check("segment pair b", 16'h4433, seg_b_q);
		// Adapter interrupts: routing, masking, clearing
		wr(cad_pkg::R_INT_ST, 32'h0000_000F);
		wr(cad_pkg::R_INT_MSK, 32'h0000_0000);
		bia_irq_n <= 1'b0;
		repeat (3) @(posedge pclk);
		check("fast interrupt", 1'b0, bus.fast_interrupt_request_n);
		check("nmi idle", 1'b1, bus.nmi_n);
		rd(cad_pkg::R_INT_ST, s);
		check("fast event", 1'b1, s[cad_pkg::EV_FAST_INTERRUPT_REQUEST]);
		check("masked irq", 1'b0, irq);
		wr(cad_pkg::R_INT_MSK, 32'h0000_0004);
		repeat (3) @(posedge pclk);
		check("unmasked irq", 1'b1, irq);
		bia_irq_n <= 1'b1;
		wr(cad_pkg::R_INT_ST, 32'h0000_0004);
		repeat (3) @(posedge pclk);
		check("cleared irq", 1'b0, irq);
		vio_irq_n <= 1'b0;
		wr(cad_pkg::R_INT_MSK, 32'h0000_0000);
		repeat (3) @(posedge pclk);
		check("nmi", 1'b0, bus.nmi_n);
		check("nmi unmaskable", 1'b1, irq);
		vio_irq_n <= 1'b1;
		wr(cad_pkg::R_INT_ST, 32'h0000_0008);
		repeat (3) @(posedge pclk);
		check("nmi cleared", 1'b0, irq);
		// Tick period from a clear, then acknowledge
		xfer(cad_pkg::A_TICK_CLR, 1'b0, 8'h00, q);
		n = 0;
		while (bus.irq_n !== 1'b0) begin
			@(posedge pclk);
			if (bus.e_stb === 1'b1)
				n++;
		end
		check("tick period", 32'h0000_0800, n);
		rd(cad_pkg::R_INT_ST, s);
		check("tick event", 1'b1, s[cad_pkg::EV_IRQ]);
		check("done event", 1'b1, s[cad_pkg::EV_DONE]);
		xfer(cad_pkg::A_TICK_CLR, 1'b0, 8'h00, q);
		repeat (2) @(posedge pclk);
		check("tick withdrawn", 1'b1, bus.irq_n);
		rd(cad_pkg::R_ADDR, s);
		check("order address", {16'h0000, cad_pkg::A_TICK_CLR}, s);
		// Second reset: orders refused while the system reset is held
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		wr(cad_pkg::R_CTRL, 32'h0000_0001);
		rd(cad_pkg::R_STATUS, s);
		check("go refused", 1'b0, s[cad_pkg::ST_BUSY]);
		check("reset again", 1'b0, s[cad_pkg::ST_RST]);
		check("bus idle", 1'b0, bus.vld);
		end_of_test();
	end
endmodule // cad_tb_top
`default_nettype wire
